// ### hdl/sfcs_regs.vh
`ifndef SFCS_REGS_VH
`define SFCS_REGS_VH

// Timing in its own units; cycle counts are derived here, rounded up to whole clock periods
`define SFCS_CLK_PERIOD_NS 50
`define SFCS_CLEAR_TIME_NS 1000000
`define SFCS_PROG_MIN_NS 500
`define SFCS_PROG_MIN_CYC ((`SFCS_PROG_MIN_NS + `SFCS_CLK_PERIOD_NS - 1) / `SFCS_CLK_PERIOD_NS)
`define SFCS_CLEAR_CYC ((`SFCS_CLEAR_TIME_NS + `SFCS_CLK_PERIOD_NS - 1) / `SFCS_CLK_PERIOD_NS)

// Configuration clock: half period in system cycles
`define SFCS_CONFIG_CLOCK_OUT_HALF 8'h08

// Flash read sequence
`define SFCS_CMD_READ 8'h03
`define SFCS_START_ADDR 24'h00_0000
`define SFCS_CMD_LAST 6'h1f

// Synchroniser reset value
`define SFCS_SYNC_RST 12'h000

`endif

// ### hdl/sfcs_sync.v
`default_nettype none

// Three-stage synchroniser; a change counts once stages two and three agree
module sfcs_sync #(
    parameter W = 1
) (
    input wire clock,
    input wire srst,
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);

reg [W-1:0] s1_reg;
reg [W-1:0] s2_reg;
reg [W-1:0] s3_reg;
integer i;

always @(posedge clock) begin
    if (srst) begin
        s1_reg <= {W{1'b0}};
        s2_reg <= {W{1'b0}};
        s3_reg <= {W{1'b0}};
        q_out <= {W{1'b0}};
    end else begin
        s1_reg <= d_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        for (i = 0; i < W; i = i + 1) begin
            if (s2_reg[i] == s3_reg[i]) begin
                q_out[i] <= s3_reg[i];
            end
        end
    end
end

endmodule // sfcs_sync

`default_nettype wire

// ### hdl/sfcs_clkdiv.v
`default_nettype none

// Configuration clock divider with rise and fall enable pulses
module sfcs_clkdiv #(
    parameter [7:0] HALF = 8'h08
) (
    input wire clock,
    input wire srst,
    input wire run,
    output reg clk_out,
    output wire rise_en,
    output wire fall_en
);

reg [7:0] cnt_reg;
wire wrap;

assign wrap = run && (cnt_reg == HALF - 8'h01);
assign rise_en = wrap && !clk_out;
assign fall_en = wrap && clk_out;

// Stopped clock rests low so the first edge seen by the flash is a rise
always @(posedge clock) begin
    if (srst || !run) begin
        cnt_reg <= 8'h00;
        clk_out <= 1'b0;
    end else if (wrap) begin
        cnt_reg <= 8'h00;
        clk_out <= !clk_out;
    end else begin
        cnt_reg <= cnt_reg + 8'h01;
    end
end

endmodule // sfcs_clkdiv

`default_nettype wire

// ### hdl/sfcs_top.v
`include "sfcs_regs.vh"
`default_nettype none

module sfcs_top #(
    parameter CLEAR_CYCLES = `SFCS_CLEAR_CYC
) (
    input wire clock,
    input wire srst,
    input wire por_vccint_ok,
    input wire por_vccaux_ok,
    input wire por_vcco_ok,
    input wire reprogram_n,
    input wire init_in,
    input wire [2:0] mode_sel,
    input wire [2:0] variant_sel,
    input wire flash_miso,
    input wire core_crc_error,
    input wire core_load_done,
    input wire core_chain_pass,
    output wire init_out,
    output wire init_oe,
    output wire done_out,
    output wire done_oe,
    output reg flash_select_n,
    output wire flash_select_oe,
    output reg flash_mosi,
    output wire flash_mosi_oe,
    output wire config_clock_out,
    output wire config_clock_oe,
    output reg chain_out,
    output wire chain_oe,
    output reg bit_data,
    output reg bit_valid,
    output reg [2:0] mode_latched,
    output reg [2:0] variant_latched,
    output wire pins_hiz,
    output wire configured,
    output wire config_failed
);

////////////////////////////////////////////////////////////////////////////////
// States

localparam [3:0] S_POR = 4'h0;
localparam [3:0] S_CLEAR = 4'h1;
localparam [3:0] S_RELEASE = 4'h2;
localparam [3:0] S_SELECT = 4'h3;
localparam [3:0] S_CMD = 4'h4;
localparam [3:0] S_LOAD = 4'h5;
localparam [3:0] S_DONE = 4'h6;
localparam [3:0] S_FAIL = 4'h7;
localparam [3:0] S_HOLD = 4'h8;

// Clear count is 16 bits wide; a longer clear time needs a wider counter
localparam [31:0] PROG_MIN_W = `SFCS_PROG_MIN_CYC;
localparam [4:0] PROG_MIN = PROG_MIN_W[4:0];
localparam [31:0] CLEAR_LAST_W = CLEAR_CYCLES - 1;
localparam [15:0] CLEAR_LAST = CLEAR_LAST_W[15:0];
localparam [7:0] CMD_READ = `SFCS_CMD_READ;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

wire [11:0] pin_raw;
wire [11:0] pin_s;
wire por_ok;
wire prog_s;
wire init_s;
wire miso_s;
wire [2:0] mode_s;
wire [2:0] variant_s;

assign pin_raw = {variant_sel, mode_sel, flash_miso, init_in, reprogram_n,
    por_vcco_ok, por_vccaux_ok, por_vccint_ok};

sfcs_sync #(
    .W(12)
) u_sync (
    .clock(clock),
    .srst(srst),
    .d_in(pin_raw),
    .q_out(pin_s)
);

assign por_ok = &pin_s[2:0];
assign prog_s = pin_s[3];
assign init_s = pin_s[4];
assign miso_s = pin_s[5];
assign mode_s = pin_s[8:6];
assign variant_s = pin_s[11:9];

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [3:0] state_reg;
reg [3:0] state_next;
reg [4:0] prog_cnt_reg;
reg [15:0] clr_cnt_reg;
reg [5:0] bit_cnt_reg;
reg [31:0] shift_reg;

wire prog_long;
wire config_clock_out_run;
wire config_clock_out_rise;
wire config_clock_out_fall;

// Short glitches on reprogram are ignored; only a full-length low counts
assign prog_long = (prog_cnt_reg >= PROG_MIN);

////////////////////////////////////////////////////////////////////////////////
// Configuration clock

assign config_clock_out_run = (state_reg == S_CMD) || (state_reg == S_LOAD);

sfcs_clkdiv #(
    .HALF(`SFCS_CONFIG_CLOCK_OUT_HALF)
) u_config_clock_out (
    .clock(clock),
    .srst(srst),
    .run(config_clock_out_run),
    .clk_out(config_clock_out),
    .rise_en(config_clock_out_rise),
    .fall_en(config_clock_out_fall)
);

////////////////////////////////////////////////////////////////////////////////
// State machine

always @* begin
    state_next = state_reg;
    case (state_reg)
    S_POR: begin
        if (por_ok && prog_s) begin
            state_next = S_CLEAR;
        end
    end
    S_CLEAR: begin
        if (clr_cnt_reg == CLEAR_LAST) begin
            state_next = S_RELEASE;
        end
    end
    S_RELEASE: begin
        // External parties may stretch this by holding init low
        if (init_s) begin
            state_next = S_SELECT;
        end
    end
    S_SELECT: begin
        state_next = S_CMD;
    end
    S_CMD: begin
        if (config_clock_out_rise && (bit_cnt_reg == `SFCS_CMD_LAST)) begin
            state_next = S_LOAD;
        end
    end
    S_LOAD: begin
        if (core_crc_error) begin
            state_next = S_FAIL;
        end else if (core_load_done) begin
            state_next = S_DONE;
        end
    end
    S_DONE: begin
        state_next = S_DONE;
    end
    S_FAIL: begin
        // No retry: only reprogram or a power loss leaves this state
        state_next = S_FAIL;
    end
    S_HOLD: begin
        if (prog_s) begin
            state_next = S_CLEAR;
        end
    end
    default: begin
        state_next = S_POR;
    end
    endcase
    if (!por_ok) begin
        state_next = S_POR;
    end else if (!prog_s && prog_long) begin
        state_next = S_HOLD;
    end
end

always @(posedge clock) begin
    if (srst) begin
        state_reg <= S_POR;
        bit_cnt_reg <= 6'h00;
        shift_reg <= 32'h0000_0000;
        flash_select_n <= 1'b1;
        flash_mosi <= 1'b0;
        chain_out <= 1'b0;
        bit_data <= 1'b0;
        bit_valid <= 1'b0;
    end else begin
        state_reg <= state_next;
        bit_valid <= 1'b0;

        case (state_reg)
        S_SELECT: begin
            // Command loaded once per configuration attempt
            flash_select_n <= 1'b0;
            shift_reg <= {CMD_READ, `SFCS_START_ADDR};
            flash_mosi <= CMD_READ[7];
            bit_cnt_reg <= 6'h00;
        end
        S_CMD: begin
            if (config_clock_out_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
            if (config_clock_out_fall) begin
                shift_reg <= {shift_reg[30:0], 1'b0};
                flash_mosi <= shift_reg[30];
            end
        end
        S_LOAD: begin
            flash_mosi <= 1'b0;
            // Deselect with the state change so the end state starts idle
            if (core_crc_error || core_load_done) begin
                flash_select_n <= 1'b1;
            end
            if (config_clock_out_rise) begin
                bit_data <= miso_s;
                bit_valid <= 1'b1;
                if (core_chain_pass) begin
                    chain_out <= miso_s;
                end
            end
        end
        default: begin
            flash_select_n <= 1'b1;
            flash_mosi <= 1'b0;
        end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Counters and latches

// Low time saturates so a long hold never wraps back into a short one
always @(posedge clock) begin
    if (srst || prog_s) begin
        prog_cnt_reg <= 5'h00;
    end else if (!prog_long) begin
        prog_cnt_reg <= prog_cnt_reg + 5'h01;
    end
end

// Clear time restarts from zero on every entry to the clear phase
always @(posedge clock) begin
    if (srst || (state_reg != S_CLEAR)) begin
        clr_cnt_reg <= 16'h0000;
    end else begin
        clr_cnt_reg <= clr_cnt_reg + 16'h0001;
    end
end

// Mode pins are taken once, on the edge where released init is seen
always @(posedge clock) begin
    if (srst) begin
        mode_latched <= 3'h0;
        variant_latched <= 3'h0;
    end else if ((state_reg == S_RELEASE) && init_s) begin
        mode_latched <= mode_s;
        variant_latched <= variant_s;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers

// Open-drain pins only ever drive low; release lets the pull-up decide
assign pins_hiz = (state_reg == S_HOLD);
assign init_out = 1'b0;
assign init_oe = (state_reg == S_CLEAR) || (state_reg == S_FAIL);
assign done_out = 1'b0;
assign done_oe = !pins_hiz && (state_reg != S_DONE);
assign flash_select_oe = !pins_hiz;
assign flash_mosi_oe = !pins_hiz;
assign config_clock_oe = !pins_hiz;
assign chain_oe = !pins_hiz;
assign configured = (state_reg == S_DONE);
assign config_failed = (state_reg == S_FAIL);

endmodule // sfcs_top

`default_nettype wire

// ### sim/sfcs_chk.sv
`default_nettype none
module sfcs_chk #(
    parameter CLEAR_CYCLES = 20
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic por_vcco_ok,
    input wire logic reprogram_n,
    input wire logic init_oe,
    input wire logic done_oe,
    input wire logic flash_select_n,
    input wire logic flash_select_oe,
    input wire logic flash_mosi_oe,
    input wire logic config_clock_out,
    input wire logic config_clock_oe,
    input wire logic chain_oe,
    input wire logic bit_valid,
    input wire logic pins_hiz,
    input wire logic configured,
    input wire logic config_failed
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    int init_cnt;
    always @(posedge clock) init_cnt <= srst ? 0 : (init_oe ? init_cnt + 1 : 0);
    ////////////////////////////////////////
    sequence s_clk_high;
        config_clock_out [*8] ##1 !config_clock_out;
    endsequence
    a_hiz_all_off: assert property (
        pins_hiz |-> !(flash_select_oe || flash_mosi_oe || config_clock_oe
        || chain_oe || done_oe)) else $error("pin driven in hold");
    a_clear_len: assert property (
        $fell(init_oe) |-> pins_hiz || (init_cnt >= CLEAR_CYCLES
        && init_cnt <= CLEAR_CYCLES + 1)) else $error("clear length");
    a_sel_after_init: assert property (
        $fell(flash_select_n) |-> !init_oe && !$past(init_oe, 3))
        else $error("select before init release");
    a_start_por: assert property (
        $fell(flash_select_n) |-> $past(por_vcco_ok, 8))
        else $error("start without supply");
    a_start_rp: assert property (
        $fell(flash_select_n) |-> $past(reprogram_n, 8))
        else $error("start while reprogram low");
    a_sel_held: assert property (
        $rose(flash_select_n) |-> configured || config_failed || pins_hiz
        || !por_vcco_ok) else $error("select dropped early");
    a_done_quiet: assert property (
        configured |-> !done_oe && flash_select_n) else $error("done state");
    a_fail_init: assert property (
        config_failed |-> init_oe && done_oe) else $error("fail state");
    // A stop by deselect or hold may cut the high phase short
    a_clk_shape: assert property (
        $rose(config_clock_out) |-> s_clk_high
        or (##[1:8] (flash_select_n || pins_hiz))) else $error("clock shape");
    a_valid_pulse: assert property (
        bit_valid |=> !bit_valid [*8]) else $error("bit pulse spacing");
endmodule // sfcs_chk
bind sfcs_top sfcs_chk #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_sfcs_chk (
    .clock, .srst, .por_vcco_ok, .reprogram_n, .init_oe, .done_oe,
    .flash_select_n, .flash_select_oe, .flash_mosi_oe, .config_clock_out,
    .config_clock_oe, .chain_oe, .bit_valid, .pins_hiz, .configured,
    .config_failed
);
`default_nettype wire

// ### sim/sfcs_flash.sv
`default_nettype none
module sfcs_flash (
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    output var logic miso,
    output var logic [31:0] cmd,
    output var int n_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    initial begin
        miso = 1'b0;
        cmd = 32'h0000_0000;
        n_sel = 0;
    end
    // Ready at once: the read is taken as soon as select falls
    always @(negedge sel_n) begin
        n_sel = n_sel + 1;
        n = 0;
    end
    always @(posedge sck) if (!sel_n) begin
        if (n < 32) cmd = {cmd[30:0], mosi};
        n = n + 1;
    end
    always @(negedge sck) if (!sel_n && n >= 32) miso = n[1] ^ n[2];
    // Released line shows the inverse, never a stale bit
    always @(posedge sel_n) miso = ~miso;
endmodule // sfcs_flash
`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CLR = 20;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic por = 1'b0;
    logic por_aux = 1'b0;
    logic reprogram_n = 1'b1;
    logic hold_init = 1'b0;
    logic [2:0] mode_sel = 3'h1;
    logic [2:0] variant_sel = 3'h5;
    logic core_crc_error = 1'b0;
    logic core_load_done = 1'b0;
    logic core_chain_pass = 1'b1;
    logic [31:0] cmd;
    int n_sel, n_mismatch = 0, n_checks = 0, cyc = 0, i, j;
    wire logic flash_miso, init_out, init_oe, done_out, done_oe;
    wire logic flash_select_n, flash_select_oe, flash_mosi, flash_mosi_oe;
    wire logic config_clock_out, config_clock_oe, chain_out, chain_oe;
    wire logic bit_data, bit_valid, pins_hiz, configured, config_failed;
    wire logic [2:0] mode_latched, variant_latched;
    // Open-drain init wire: low while either side pulls it
    wire logic init_in = !(init_oe || hold_init);
    sfcs_top #(.CLEAR_CYCLES(CLR)) u_sfcs_top (
        .clock, .srst, .por_vccint_ok(por), .por_vccaux_ok(por_aux),
        .por_vcco_ok(por), .reprogram_n, .init_in, .mode_sel, .variant_sel,
        .flash_miso, .core_crc_error, .core_load_done, .core_chain_pass,
        .init_out, .init_oe, .done_out, .done_oe, .flash_select_n,
        .flash_select_oe, .flash_mosi, .flash_mosi_oe, .config_clock_out,
        .config_clock_oe, .chain_out, .chain_oe, .bit_data, .bit_valid,
        .mode_latched, .variant_latched, .pins_hiz, .configured,
        .config_failed
    );
    sfcs_flash u_sfcs_flash (.sel_n(flash_select_n), .sck(config_clock_out),
        .mosi(flash_mosi), .miso(flash_miso), .cmd, .n_sel);
    ////////////////////////////////////////
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Command phase, eight stream bits, then a done or crc pulse
    task load(input logic crc);
        j = 0;
        for (i = 0; i < 1000 && j < 8; i++) begin
            tick(1);
            if (bit_valid === 1'b1) begin
                chk("bit", j[1] ^ j[2], bit_data);
                tick(1);
                // A gated chain keeps its last forwarded bit, which was zero
                chk("chain", core_chain_pass ? j[1] ^ j[2] : 0, chain_out);
                j++;
            end
        end
        chk("command", 32'h0300_0000, cmd);
        chk("held", 0, flash_select_n);
        if (crc) core_crc_error = 1'b1;
        else core_load_done = 1'b1;
        tick(1);
        core_crc_error = 1'b0;
        core_load_done = 1'b0;
        tick(2);
        chk("deselect", 1, flash_select_n);
    endtask
    task t_boot;
        tick(50);
        chk("select before por", 1, flash_select_n);
        chk("done low", 1, done_oe);
        chk("pins on", 5'h1f, {flash_select_oe, flash_mosi_oe,
            config_clock_oe, chain_oe, done_oe});
        chk("open drain low", 0, {init_out, done_out});
        por = 1'b1;
        tick(20);
        chk("wait aux supply", 0, init_oe);
        chk("no select on two", 1, flash_select_n);
        por_aux = 1'b1;
        for (i = 0; i < 20 && init_oe !== 1'b1; i++) tick(1);
        chk("init clearing", 1, init_oe);
        for (j = 0; j < 200 && init_oe === 1'b1; j++) tick(1);
        chk("clear length", CLR, j);
        for (i = 0; i < 20 && flash_select_n !== 1'b0; i++) tick(1);
        chk("select", 0, flash_select_n);
        chk("mode", 3'h1, mode_latched);
        chk("variant", 3'h5, variant_latched);
        load(1'b0);
        chk("configured", 1, configured);
        chk("done released", 0, done_oe);
        $display("test boot done");
    endtask
    task t_short;
        reprogram_n = 1'b0;
        tick(5);
        reprogram_n = 1'b1;
        tick(30);
        chk("short pulse", 1, configured);
        chk("no restart", 1, n_sel);
        $display("test short done");
    endtask
    task t_reprog;
        reprogram_n = 1'b0;
        tick(30);
        chk("hiz", 1, pins_hiz);
        chk("pins off", 0, {flash_select_oe, flash_mosi_oe,
            config_clock_oe, chain_oe, done_oe});
        chk("unconfigured", 0, configured);
        hold_init = 1'b1;
        core_chain_pass = 1'b0;
        mode_sel = 3'h3;
        reprogram_n = 1'b1;
        tick(100);
        chk("wait on init", 1, flash_select_n);
        chk("done reset", 1, done_oe);
        chk("one read", 1, n_sel);
        hold_init = 1'b0;
        for (i = 0; i < 80 && flash_select_n !== 1'b0; i++) tick(1);
        chk("mode again", 3'h3, mode_latched);
        load(1'b1);
        chk("crc flag", 1, init_oe);
        tick(300);
        chk("no retry", 2, n_sel);
        chk("failed", 1, config_failed);
        $display("test reprogram done");
    endtask
    initial forever #25 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict();
        end
    end
    initial begin
        tick(8);
        srst = 1'b0;
        t_boot();
        t_short();
        t_reprog();
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
